// ===== tb_video_pixel_stream_port.sv
// Purpose: self-checking bench for the device and its source and sink neighbours
// Assumes: clk_sys at 250 MHz, reset_n held low for 16 cycles
// Notes: three pairs run the parallel, sequential and luma/chroma layouts side by side
`timescale 1ns/10ps
`default_nettype none
`include "vps_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_video_pixel_stream_port;
  import vps_pkg::*;
  localparam int FW = 4;
  localparam int FH = 3;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic invert_en = 1'b0;
  logic src_en = 1'b0;
  logic src_hold = 1'b0;
  logic snk_stall = 1'b0;
  logic inv_exp = 1'b0;
  int err_count = 0;
  int compares = 0;
  int unsigned seed = 3;
  int fcnt = 0;
  int rcv [3] = '{0, 0, 0};
  int sent [3] = '{0, 0, 0};
  logic [2:0] rdy = 3'h0;
  logic [2:0] strobe, in_err, snk_err;
  logic [29:0] g0;
  logic [7:0] g1;
  logic [19:0] g2;
  logic [2:0] rend, fend, sdone;
  vps_cnt_t px [3];
  vps_cnt_t py [3];
  int sfr [3] = '{0, 0, 0};
  int efr [3] = '{0, 0, 0};
  vps_if #(.DW(30)) vi0 ();
  vps_if #(.DW(8)) vi1 ();
  vps_if #(.DW(20)) vi2 ();
  vps_dev #(.BPS(10), .SPB(3), .MODE(VPS_MODE_PAR), .FRAME_W(FW), .FRAME_H(FH)) vps_dev_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(vi0.dev), .invert_en(invert_en),
    .in_err_q(in_err[0]), .row_end_q(rend[0]), .frame_end_q(fend[0]), .pix_x_q(px[0]),
    .pix_y_q(py[0]));
  vps_dev #(.BPS(8), .SPB(1), .MODE(VPS_MODE_SEQ), .FRAME_W(FW), .FRAME_H(FH)) vps_dev_seq_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(vi1.dev), .invert_en(invert_en),
    .in_err_q(in_err[1]), .row_end_q(rend[1]), .frame_end_q(fend[1]), .pix_x_q(px[1]),
    .pix_y_q(py[1]));
  vps_dev #(.BPS(10), .SPB(2), .MODE(VPS_MODE_YC2), .FRAME_W(FW), .FRAME_H(FH)) vps_dev_yc_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(vi2.dev), .invert_en(invert_en),
    .in_err_q(in_err[2]), .row_end_q(rend[2]), .frame_end_q(fend[2]), .pix_x_q(px[2]),
    .pix_y_q(py[2]));
  vps_ext #(.BPS(10), .SPB(3), .MODE(VPS_MODE_PAR), .FRAME_W(FW), .FRAME_H(FH)) vps_ext_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(vi0.ext), .src_en(src_en), .src_hold(src_hold),
    .snk_stall(snk_stall), .src_frame_done_q(sdone[0]), .snk_strobe_q(strobe[0]), .snk_data_q(g0),
    .snk_err_q(snk_err[0]));
  vps_ext #(.BPS(8), .SPB(1), .MODE(VPS_MODE_SEQ), .FRAME_W(FW), .FRAME_H(FH)) vps_ext_seq_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(vi1.ext), .src_en(src_en), .src_hold(src_hold),
    .snk_stall(snk_stall), .src_frame_done_q(sdone[1]), .snk_strobe_q(strobe[1]), .snk_data_q(g1),
    .snk_err_q(snk_err[1]));
  vps_ext #(.BPS(10), .SPB(2), .MODE(VPS_MODE_YC2), .FRAME_W(FW), .FRAME_H(FH)) vps_ext_yc_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(vi2.ext), .src_en(src_en), .src_hold(src_hold),
    .snk_stall(snk_stall), .src_frame_done_q(sdone[2]), .snk_strobe_q(strobe[2]), .snk_data_q(g2),
    .snk_err_q(snk_err[2]));
  vps_assertions #(.DW(30), .DEPTH(2), .ROW_BEATS(FW)) vps_assertions_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .din_ready(vi0.din_ready),
    .din_valid(vi0.din_valid), .din_data(vi0.din_data), .dout_ready(vi0.dout_ready),
    .dout_valid(vi0.dout_valid), .dout_data(vi0.dout_data));
  always #2 clk_sys = ~clk_sys;
  // ****************************************
  // expectations
  // ****************************************
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // md 0 parallel, 1 sequential, 2 luma with alternating chroma
  function automatic logic [29:0] exp_word(input int md, input int bps, input int k,
                                           input logic inv);
    int pix;
    int x;
    int pl;
    int s;
    int n;
    logic [29:0] w;
    w = '0;
    n = (md == 0) ? 3 : ((md == 1) ? 1 : 2);
    pix = ((md == 1) ? k / 3 : k) % (FW * FH);
    x = pix % FW;
    for (int i = 0; i < n; i++) begin
      pl = (md == 1) ? k % 3 : ((md == 2 && i == 1) ? 1 + x % 2 : i);
      s = (x * 4 + (pix / FW) * 16 + pl) & ((1 << bps) - 1);
      if (inv) begin
        s = ~s & ((1 << bps) - 1);
      end
      w = w | (30'(s) << (i * bps));
    end
    return w;
  endfunction
  always @(negedge clk_sys) begin
    if (reset_n) begin
      `CHK("status flags", 6'h00, {in_err, snk_err})
      if (strobe[0]) begin
        `CHK("parallel word", exp_word(0, 10, rcv[0], inv_exp), g0)
        rcv[0]++;
      end
      if (strobe[1]) begin
        `CHK("sequential word", exp_word(1, 8, rcv[1], inv_exp), g1)
        rcv[1]++;
      end
      if (strobe[2]) begin
        `CHK("luma chroma word", exp_word(2, 10, rcv[2], inv_exp), g2)
        rcv[2]++;
      end
      for (int k = 0; k < 3; k++) begin
        if (rend[k]) begin
          `CHK("row end x", vps_cnt_t'(FW - 1), px[k])
        end
        if (fend[k]) begin
          `CHK("last x", vps_cnt_t'(FW - 1), px[k])
          `CHK("last y", vps_cnt_t'(FH - 1), py[k])
        end
        sfr[k] += int'(sdone[k]);
        efr[k] += int'(fend[k]);
      end
      fcnt += int'(fend[0]);
      sent[0] += int'(vi0.din_valid && rdy[0]);
      sent[1] += int'(vi1.din_valid && rdy[1]);
      sent[2] += int'(vi2.din_valid && rdy[2]);
    end
    rdy = {vi2.din_ready, vi1.din_ready, vi0.din_ready};
  end
  // ****************************************
  // sequencing
  // ****************************************
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_frames(input int n);
    int target;
    target = fcnt + n;
    for (int i = 0; i < 4000 && fcnt < target; i++) begin
      @(negedge clk_sys);
    end
    if (fcnt < target) begin
      err_count++;
      $display("mismatch frame end expected %0d seen %0d", target, fcnt);
      finish_test();
    end
  endtask
  // random idle beats on the source and random sink stalls
  task automatic run_random(input int n);
    int unsigned r;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      r = xs();
      src_hold = (r[1:0] == 2'h0);
      snk_stall = (r[5:3] < 3'h3);
    end
  endtask
  // stop the source and let every word reach its sink
  task automatic drain();
    src_en = 1'b0;
    src_hold = 1'b0;
    snk_stall = 1'b0;
    repeat (80) @(negedge clk_sys);
    for (int k = 0; k < 3; k++) begin
      `CHK("words delivered", sent[k], rcv[k])
      `CHK("frames", sfr[k], efr[k])
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    `CHK("ready in reset", 1'b0, vi0.din_ready)
    reset_n = 1'b1;
    @(negedge clk_sys);
    `CHK("ready after reset", 1'b1, vi0.din_ready)
    src_en = 1'b1;
    wait_frames(2);
    snk_stall = 1'b1;
    repeat (20) @(negedge clk_sys);
    `CHK("input ready while stalled", 1'b0, vi0.din_ready)
    `CHK("output valid while stalled", 1'b0, vi0.dout_valid)
    snk_stall = 1'b0;
    wait_frames(1);
    run_random(3000);
    drain();
    invert_en = 1'b1;
    inv_exp = 1'b1;
    repeat (4) @(negedge clk_sys);
    src_en = 1'b1;
    run_random(2000);
    drain();
    finish_test();
  end
endmodule // tb_video_pixel_stream_port
`default_nettype wire

// ===== vps_assertions.sv
// Purpose: protocol checks on the stream wires between the device and its neighbours
// Assumes: one clock, reset_n asynchronous and active low
// Notes: occupancy counts words taken in and not yet shown on the output
`timescale 1ns/10ps
`default_nettype none
`include "vps_cfg.svh"
module vps_assertions #(
  parameter int unsigned DW = 24,
  parameter int unsigned DEPTH = 2,
  parameter int unsigned ROW_BEATS = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic din_ready,
  input wire logic din_valid,
  input wire logic [DW-1:0] din_data,
  input wire logic dout_ready,
  input wire logic dout_valid,
  input wire logic [DW-1:0] dout_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic rdy_q;
  logic [3:0] occ_q;
  logic [15:0] beat_q;
  logic taken;
  logic row_last;
  assign taken = din_valid && rdy_q;
  assign row_last = taken && (beat_q == 16'(ROW_BEATS - 1));
  // ****************************************
  // helper state
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= din_ready;
    end
  end
  // words delivered leave the count in the cycle their valid is high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      occ_q <= 4'h0;
    end else begin
      occ_q <= occ_q + 4'(taken) - 4'(dout_valid);
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      beat_q <= 16'h0000;
    end else if (taken) begin
      beat_q <= row_last ? 16'h0000 : beat_q + 16'h0001;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_sink_drop;
    dout_ready ##1 !dout_ready;
  endsequence
  sequence s_sink_open;
    (occ_q != 4'h0 && dout_ready) [*3];
  endsequence
  property p_out_after_ready;
    dout_valid |-> $past(dout_ready);
  endproperty
  property p_in_after_ready;
    din_valid |-> $past(din_ready);
  endproperty
  property p_stall_stops_out;
    s_sink_drop |=> !dout_valid;
  endproperty
  property p_hold_data;
    !dout_valid |-> $stable(dout_data);
  endproperty
  property p_no_overflow;
    occ_q <= 4'(DEPTH + 1);
  endproperty
  // stored words plus the beat promised by last cycle's ready fill the buffer
  property p_full_blocks_in;
    (occ_q - 4'(dout_valid) + 4'(rdy_q)) >= 4'(DEPTH) |-> !din_ready;
  endproperty
  property p_drain;
    s_sink_open |-> dout_valid || $past(dout_valid) || $past(dout_valid, 2);
  endproperty
  property p_row_gap;
    row_last |=> !din_ready [*4];
  endproperty
  a_out_after_ready: assert property (p_out_after_ready)
    else $error("output beat without ready in the cycle before");
  a_in_after_ready: assert property (p_in_after_ready)
    else $error("input beat without ready in the cycle before");
  a_stall_stops_out: assert property (p_stall_stops_out)
    else $error("output valid after sink dropped ready");
  a_hold_data: assert property (p_hold_data)
    else $error("output data moved while not valid");
  a_no_overflow: assert property (p_no_overflow)
    else $error("more words in flight than storage");
  a_full_blocks_in: assert property (p_full_blocks_in)
    else $error("input ready high while storage full");
  a_drain: assert property (p_drain)
    else $error("stored word not sent to a ready sink");
  a_row_gap: assert property (p_row_gap)
    else $error("input ready high inside row gap");
endmodule // vps_assertions
`default_nettype wire

// ===== vps_cfg.svh
// Purpose: shared constants of the pixel stream port pair
// Assumes: included by bare name from every design file
// Notes: figures are per beat or per clock cycle of clk_sys
`ifndef VPS_CFG_SVH
`define VPS_CFG_SVH
// ****************************************
// stream format
// ****************************************
`define VPS_BITS_PER_SAMPLE 8
`define VPS_SAMPLES_PER_BEAT 3
`define VPS_RGB_PLANES 3
`define VPS_READY_LATENCY 1
`define VPS_FRAME_WIDTH 640
`define VPS_FRAME_HEIGHT 480
// ****************************************
// device timing and storage
// ****************************************
`define VPS_ROW_GAP 4
`define VPS_FRAME_GAP 16
`define VPS_FIFO_DEPTH 2
`define VPS_CNT_W 16
// ****************************************
// colour plane codes carried by the source pattern
// ****************************************
`define VPS_PLANE_R 0
`define VPS_PLANE_G 1
`define VPS_PLANE_B 2
`define VPS_PLANE_Y 0
`define VPS_PLANE_CB 1
`define VPS_PLANE_CR 2
`endif

// ===== vps_dev.sv
// Purpose: pixel processing device with stream input and stream output
// Assumes: source and sink keep their side of the one-cycle ready latency
// Notes: words pass a two-entry buffer, so a sink stall loses nothing
//
// Overview of operation
// - ready governs transfer one cycle later
// - each port carries ready, valid, data
// - raised input ready commits to next beat
// - source raises valid only with real data
// - idle valid cycles carry no data
// - input ready drops between rows and frames
// - pixels in raster order from top left
// - parallel mode: all samples in one beat
// - sequential mode: R, G, B on successive beats
// - 10-bit RGB: three samples per beat
// - luma plus alternating chroma per beat
// - sink may drop ready any cycle
// - valid drops one cycle after sink unready
// - input ready drops before buffer overflows
// - beat after ready falls is still accepted
// - output resumes first, then input ready (here input ready rises in the same cycle as output valid)
// - source resumes after input ready rises
// - beat width is samples times sample bits
`timescale 1ns/10ps
`default_nettype none
`include "vps_cfg.svh"
module vps_dev
  import vps_pkg::*;
#(
  parameter int unsigned BPS = `VPS_BITS_PER_SAMPLE,
  parameter int unsigned SPB = `VPS_SAMPLES_PER_BEAT,
  parameter vps_pkg::vps_mode_e MODE = vps_pkg::VPS_MODE_PAR,
  parameter int unsigned FRAME_W = `VPS_FRAME_WIDTH,
  parameter int unsigned FRAME_H = `VPS_FRAME_HEIGHT,
  parameter int unsigned ROW_GAP = `VPS_ROW_GAP,
  parameter int unsigned FRAME_GAP = `VPS_FRAME_GAP,
  parameter int unsigned DEPTH = `VPS_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  vps_if.dev link,
  input wire logic invert_en,
  output logic in_err_q,
  output logic row_end_q,
  output logic frame_end_q,
  output vps_pkg::vps_cnt_t pix_x_q,
  output vps_pkg::vps_cnt_t pix_y_q
);
  import vps_pkg::*;

  // ****************************************
  // derived sizes
  // ****************************************
  // beat width
  localparam int unsigned DW = BPS * SPB;
  localparam int unsigned BPP = (MODE == VPS_MODE_SEQ) ? `VPS_RGB_PLANES : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam vps_cnt_t LAST_PLANE = vps_cnt_t'(BPP - 1);
  localparam vps_cnt_t LAST_X = vps_cnt_t'(FRAME_W - 1);
  localparam vps_cnt_t LAST_Y = vps_cnt_t'(FRAME_H - 1);
  localparam vps_cnt_t ROW_GAP_C = vps_cnt_t'(ROW_GAP);
  localparam vps_cnt_t FRAME_GAP_C = vps_cnt_t'(FRAME_GAP);

  logic din_ready_q;
  logic rdy_seen_q;
  logic dout_valid_q;
  logic [DW-1:0] dout_data_q;
  logic inv_q;
  logic in_beat;
  logic fifo_room;
  logic pop_valid;
  logic pop_go;
  logic [DW-1:0] pop_data;
  logic [CW-1:0] fifo_cnt;
  logic [CW:0] fill_next;
  logic row_last;
  logic frame_last;
  logic gap_start;
  logic din_ready_d;
  vps_cnt_t plane_q;
  vps_cnt_t x_q;
  vps_cnt_t y_q;
  vps_cnt_t gap_q;

  // ****************************************
  // sample processing
  // ****************************************
  // per-lane transform so that every sample keeps its lane and beat
  function automatic logic [DW-1:0] vps_proc(input logic [DW-1:0] d, input logic inv);
    logic [DW-1:0] r;
    r = '0;
    for (int k = 0; k < int'(SPB); k++) begin
      r[k*BPS +: BPS] = inv ? ~d[k*BPS +: BPS] : d[k*BPS +: BPS];
    end
    return r;
  endfunction

  // ****************************************
  // input handshake
  // ****************************************
  // device drives input ready
  assign link.din_ready = din_ready_q;
  assign in_beat = link.din_valid && rdy_seen_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdy_seen_q <= 1'b0;
    end else begin
      rdy_seen_q <= din_ready_q;
    end
  end

  // invert setting is registered every cycle, with no wait for a settled pipe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inv_q <= 1'b0;
    end else begin
      inv_q <= invert_en;
    end
  end

  // ****************************************
  // raster position
  // ****************************************
  // raster order tracking
  assign row_last = in_beat && (plane_q == LAST_PLANE) && (x_q == LAST_X);
  assign frame_last = row_last && (y_q == LAST_Y);
  assign gap_start = row_last;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      plane_q <= '0;
      x_q <= '0;
      y_q <= '0;
    end else if (in_beat) begin
      if (plane_q != LAST_PLANE) begin
        plane_q <= vps_cnt_t'(plane_q + 1'b1);
      end else begin
        plane_q <= '0;
        if (x_q != LAST_X) begin
          x_q <= vps_cnt_t'(x_q + 1'b1);
        end else begin
          x_q <= '0;
          y_q <= (y_q == LAST_Y) ? '0 : vps_cnt_t'(y_q + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pix_x_q <= '0;
      pix_y_q <= '0;
      row_end_q <= 1'b0;
      frame_end_q <= 1'b0;
    end else begin
      if (in_beat && (plane_q == LAST_PLANE)) begin
        pix_x_q <= x_q;
        pix_y_q <= y_q;
      end
      row_end_q <= row_last;
      frame_end_q <= frame_last;
    end
  end

  // ****************************************
  // row and frame gaps
  // ****************************************
  // ready low between rows
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= '0;
    end else if (gap_start) begin
      gap_q <= frame_last ? FRAME_GAP_C : ROW_GAP_C;
    end else if (gap_q != '0) begin
      gap_q <= vps_cnt_t'(gap_q - 1'b1);
    end
  end

  // ****************************************
  // input ready
  // ****************************************
  // a beat may still land next cycle if ready is high now, and a raised
  // ready promises one more; this cycle's pop is counted, which still costs a third of the
  // rate with two entries, two beats in three cycles, but can never overflow
  assign fill_next = (CW+1)'(fifo_cnt) + (CW+1)'(in_beat) - (CW+1)'(pop_go);
  assign din_ready_d = !gap_start && (gap_q <= vps_cnt_t'(1)) &&
                       ((fill_next + (CW+1)'(din_ready_q)) < (CW+1)'(DEPTH));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      din_ready_q <= 1'b0;
    end else begin
      din_ready_q <= din_ready_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_err_q <= 1'b0;
    end else begin
      in_err_q <= (link.din_valid && !rdy_seen_q) || (in_beat && !fifo_room);
    end
  end

  // ****************************************
  // buffer
  // ****************************************
  // late beat still stored
  vps_fifo #(
    .W(DW),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .push_valid(in_beat),
    .push_ready(fifo_room),
    .push_data(vps_proc(link.din_data, inv_q)),
    .pop_valid(pop_valid),
    .pop_ready(link.dout_ready),
    .pop_data(pop_data),
    .count(fifo_cnt)
  );

  // ****************************************
  // output handshake
  // ****************************************
  // popping only on a ready sink makes the next cycle a sure transfer
  assign pop_go = pop_valid && link.dout_ready;
  assign link.dout_valid = dout_valid_q;
  assign link.dout_data = dout_data_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dout_valid_q <= 1'b0;
      dout_data_q <= '0;
    end else begin
      dout_valid_q <= pop_go;
      if (pop_go) begin
        dout_data_q <= pop_data;
      end
    end
  end
endmodule // vps_dev
`default_nettype wire

// ===== vps_ext.sv
// Purpose: upstream pattern source and downstream sink around the device
// Assumes: device keeps the one-cycle ready latency on both ports
// Notes: source pattern encodes x, y and plane so order can be checked
`timescale 1ns/10ps
`default_nettype none
`include "vps_cfg.svh"
module vps_ext
  import vps_pkg::*;
#(
  parameter int unsigned BPS = `VPS_BITS_PER_SAMPLE,
  parameter int unsigned SPB = `VPS_SAMPLES_PER_BEAT,
  parameter vps_pkg::vps_mode_e MODE = vps_pkg::VPS_MODE_PAR,
  parameter int unsigned FRAME_W = `VPS_FRAME_WIDTH,
  parameter int unsigned FRAME_H = `VPS_FRAME_HEIGHT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  vps_if.ext link,
  input wire logic src_en,
  input wire logic src_hold,
  input wire logic snk_stall,
  output logic src_frame_done_q,
  output logic snk_strobe_q,
  output logic [BPS*SPB-1:0] snk_data_q,
  output logic snk_err_q
);
  import vps_pkg::*;

  localparam int unsigned DW = BPS * SPB;
  localparam int unsigned BPP = (MODE == VPS_MODE_SEQ) ? `VPS_RGB_PLANES : 1;
  localparam vps_cnt_t LAST_PLANE = vps_cnt_t'(BPP - 1);
  localparam vps_cnt_t LAST_X = vps_cnt_t'(FRAME_W - 1);
  localparam vps_cnt_t LAST_Y = vps_cnt_t'(FRAME_H - 1);

  logic din_valid_q;
  logic [DW-1:0] din_data_q;
  logic dout_ready_q;
  logic snk_seen_q;
  logic send;
  vps_cnt_t plane_q;
  vps_cnt_t x_q;
  vps_cnt_t y_q;

  // sample value carries its own coordinates and plane code
  function automatic logic [BPS-1:0] vps_sample(input vps_cnt_t x, input vps_cnt_t y,
                                                input int unsigned p);
    logic [31:0] t;
    t = 32'(x) * 32'h4 + 32'(y) * 32'h10 + 32'(p);
    return t[BPS-1:0];
  endfunction

  function automatic logic [DW-1:0] vps_beat(input vps_cnt_t x, input vps_cnt_t y,
                                             input vps_cnt_t pl);
    logic [DW-1:0] r;
    r = '0;
    for (int k = 0; k < int'(SPB); k++) begin
      unique case (MODE)
        VPS_MODE_SEQ: r[k*BPS +: BPS] = vps_sample(x, y, 32'(pl));
        VPS_MODE_YC2: r[k*BPS +: BPS] = vps_sample(x, y, (k == 0) ? `VPS_PLANE_Y :
                                          (x[0] ? `VPS_PLANE_CR : `VPS_PLANE_CB));
        VPS_MODE_PAR: r[k*BPS +: BPS] = vps_sample(x, y, 32'(k));
      endcase
    end
    return r;
  endfunction

  // ****************************************
  // source
  // ****************************************
  // send only on current ready
  assign send = src_en && !src_hold && link.din_ready;
  assign link.din_valid = din_valid_q;
  assign link.din_data = din_data_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      din_valid_q <= 1'b0;
      din_data_q <= '0;
    end else begin
      din_valid_q <= send;
      if (send) begin
        din_data_q <= vps_beat(x_q, y_q, plane_q);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      plane_q <= '0;
      x_q <= '0;
      y_q <= '0;
      src_frame_done_q <= 1'b0;
    end else begin
      src_frame_done_q <= send && (plane_q == LAST_PLANE) && (x_q == LAST_X) && (y_q == LAST_Y);
      if (send) begin
        if (plane_q != LAST_PLANE) begin
          plane_q <= vps_cnt_t'(plane_q + 1'b1);
        end else begin
          plane_q <= '0;
          if (x_q != LAST_X) begin
            x_q <= vps_cnt_t'(x_q + 1'b1);
          end else begin
            x_q <= '0;
            y_q <= (y_q == LAST_Y) ? '0 : vps_cnt_t'(y_q + 1'b1);
          end
        end
      end
    end
  end

  // ****************************************
  // sink
  // ****************************************
  // ready drop on request
  assign link.dout_ready = dout_ready_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dout_ready_q <= 1'b0;
      snk_seen_q <= 1'b0;
    end else begin
      dout_ready_q <= !snk_stall;
      snk_seen_q <= dout_ready_q;
    end
  end

  // capture on valid and prior ready
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      snk_strobe_q <= 1'b0;
      snk_data_q <= '0;
      snk_err_q <= 1'b0;
    end else begin
      snk_strobe_q <= link.dout_valid && snk_seen_q;
      snk_err_q <= link.dout_valid && !snk_seen_q;
      if (link.dout_valid && snk_seen_q) begin
        snk_data_q <= link.dout_data;
      end
    end
  end
endmodule // vps_ext
`default_nettype wire

// ===== vps_fifo.sv
// Purpose: small word buffer between the capture and output stages
// Assumes: push and pop may happen in the same cycle
// Notes: no fall-through, a pushed word is poppable one cycle later
`timescale 1ns/10ps
`default_nettype none
`include "vps_cfg.svh"
module vps_fifo #(
  parameter int unsigned W = 24,
  parameter int unsigned DEPTH = `VPS_FIFO_DEPTH,
  parameter int unsigned CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [W-1:0] push_data,
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [W-1:0] pop_data,
  output logic [CW-1:0] count
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] vps_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign push_ready = (cnt_q != CW'(DEPTH));
  assign pop_valid = (cnt_q != '0);
  assign pop_data = mem_q[rd_q];
  assign count = cnt_q;
  assign do_push = push_valid && push_ready;
  assign do_pop = pop_valid && pop_ready;

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= vps_inc(wr_q);
      end
      if (do_pop) begin
        rd_q <= vps_inc(rd_q);
      end
      cnt_q <= CW'(cnt_q + CW'(do_push) - CW'(do_pop));
    end
  end
endmodule // vps_fifo
`default_nettype wire

// ===== vps_if.sv
// Purpose: input and output stream wires between device and its neighbours
// Assumes: one clock shared by all parties
// Notes: ext is the upstream source plus the downstream sink
`timescale 1ns/10ps
`default_nettype none
`include "vps_cfg.svh"
interface vps_if #(
  parameter int unsigned DW = `VPS_BITS_PER_SAMPLE * `VPS_SAMPLES_PER_BEAT
);
  logic din_ready;
  logic din_valid;
  logic [DW-1:0] din_data;
  logic dout_ready;
  logic dout_valid;
  logic [DW-1:0] dout_data;
  modport dev (
    output din_ready,
    input din_valid,
    input din_data,
    input dout_ready,
    output dout_valid,
    output dout_data
  );
  modport ext (
    input din_ready,
    output din_valid,
    output din_data,
    output dout_ready,
    input dout_valid,
    input dout_data
  );
endinterface // vps_if
`default_nettype wire

// ===== vps_pkg.sv
// Purpose: types shared by both ends of the pixel stream
// Assumes: constants live in vps_cfg.svh
// Notes: mode selects how samples of a pixel sit on the beats
`include "vps_cfg.svh"
package vps_pkg;
  typedef enum logic [1:0] {
    VPS_MODE_PAR = 2'h0,
    VPS_MODE_SEQ = 2'h1,
    VPS_MODE_YC2 = 2'h2
  } vps_mode_e;
  typedef logic [`VPS_CNT_W-1:0] vps_cnt_t;
endpackage
